// *** hw/reset_flag_pkg.sv ***
package reset_flag_pkg;

  // ----------------------------------------------------------------
  // reset source indices
  // ----------------------------------------------------------------
  localparam int unsigned SRC_COUNT = 6;
  localparam int unsigned SRC_CPU_FAIL = 0;
  localparam int unsigned SRC_CPU_SOFT = 1;
  localparam int unsigned SRC_CPU_PANEL = 2;
  localparam int unsigned SRC_BRD_SOFT = 3;
  localparam int unsigned SRC_BRD_PANEL = 4;
  localparam int unsigned SRC_BRD_WDOG = 5;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  // only the two panel sources enabled by default
  localparam logic [5:0] ENABLE_DEFAULT = 6'h14;
  // mask of sources that actually generate resets (soft ones do not)
  localparam logic [5:0] SRC_LIVE_MASK = 6'h35;
  localparam logic [5:0] SRC_CPU_MASK = 6'h07;
  localparam logic [5:0] SRC_BRD_MASK = 6'h38;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 125000000;
  localparam int unsigned SYNC_FREQ_HZ = 1250000;
  // half period of the sync clock in system clocks
  localparam int unsigned SYNC_HALF_CYCLES = CLK_FREQ_HZ / (2 * SYNC_FREQ_HZ);
  localparam int unsigned WDOG_TIMEOUT_CYCLES = 125000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // origin record for one section
  typedef struct packed {
    logic valid;
    logic [2:0] source;
  } reset_origin_t;

  // sync clock role
  typedef enum logic [1:0] {
    SYNC_SLAVE = 2'b01,
    SYNC_MASTER = 2'b10
  } sync_role_t;

endpackage

// *** hw/reset_flag_sync.sv ***
`timescale 1ns/1ps
// What this block does
// - four of the six reset sources (not the two soft ones) can raise the indicator
// - first enabled source occurrence raises indicator
// - indicator led follows indicator output
// - each source gated by its own enable
// - cpu panel request ignored when cpu panel disabled
// - defaults: only both panel sources enabled
// - board watchdog resets board when unserviced
// - soft reset enables held, resets not generated
// - record origin of last cpu, board reset
// - master: generate 1.25 MHz, drive, led on
// - slave: sync pin input, led off
module reset_flag_sync
  import reset_flag_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WDOG_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // configuration
  input wire logic load_defaults,
  input wire logic cfg_write,
  input wire logic [5:0] cfg_enable,
  input wire logic sync_master_sel,
  // reset source events, one-cycle pulses
  input wire logic cpu_failure_reset_source,
  input wire logic cpu_user_soft_reset_source,
  input wire logic cpu_panel_reset_source,
  input wire logic board_user_soft_reset_source,
  input wire logic board_panel_reset_source,
  // watchdog service from board firmware
  input wire logic wdog_kick,
  // reset outputs
  output logic cpu_reset,
  output logic board_reset,
  output logic reset_flag,
  output logic reset_flag_led,
  // status
  output logic [5:0] enable_state,
  output reset_origin_t cpu_origin,
  output reset_origin_t board_origin,
  // sync clock pin
  input wire logic supply_sync_clock_in,
  output logic supply_sync_clock_out,
  output logic supply_sync_clock_oe,
  output logic master_led,
  output logic sync_clock_seen
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [5:0] enable_q, enable_d; // per-source enables
  logic flag_q, flag_d; // sticky indicator
  logic cpu_rst_q, cpu_rst_d;
  logic brd_rst_q, brd_rst_d;
  reset_origin_t cpu_org_q, cpu_org_d;
  reset_origin_t brd_org_q, brd_org_d;
  logic [16:0] wdog_q, wdog_d; // watchdog counter
  logic [5:0] raw; // raw source events
  logic [5:0] fired; // enabled, live events
  logic [5:0] half_q, half_d; // sync divider
  logic sync_q, sync_d;
  sync_role_t role_q, role_d;
  logic in_q, in_d; // sampled incoming sync clock
  logic seen_q, seen_d;
  // slave role already held last cycle, so in_q holds a far-side sample
  logic listen_q, listen_d;
  logic wdog_expire;

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  // watchdog expires when the count reaches one less than the timeout
  assign wdog_expire = (wdog_q == 17'(WDOG_CYCLES - 1));

  // collect the six sources in index order
  always_comb begin
    raw = 6'h00;
    raw[SRC_CPU_FAIL] = cpu_failure_reset_source;
    raw[SRC_CPU_SOFT] = cpu_user_soft_reset_source;
    raw[SRC_CPU_PANEL] = cpu_panel_reset_source;
    raw[SRC_BRD_SOFT] = board_user_soft_reset_source;
    raw[SRC_BRD_PANEL] = board_panel_reset_source;
    raw[SRC_BRD_WDOG] = wdog_expire;
    // soft sources are masked off: not functional yet
    fired = raw & enable_q & SRC_LIVE_MASK;
  end

  // priority encode the lowest firing index in a mask
  function automatic logic [2:0] first_src(input logic [5:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = SRC_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // reset flag and origin logic
  // ----------------------------------------------------------------
  // next values for enables, flag, section resets and records
  always_comb begin
    enable_d = enable_q;
    flag_d = flag_q;
    cpu_org_d = cpu_org_q;
    brd_org_d = brd_org_q;
    wdog_d = wdog_q;
    // section resets are one-cycle pulses
    cpu_rst_d = |(fired & SRC_CPU_MASK);
    brd_rst_d = |(fired & SRC_BRD_MASK);
    if (load_defaults) begin
      enable_d = ENABLE_DEFAULT;
    end else if (cfg_write) begin
      enable_d = cfg_enable;
    end
    // reconfiguring clears the flag, but a same-cycle event still wins
    if (load_defaults || cfg_write) begin
      flag_d = 1'b0;
    end
    if (|fired) begin
      flag_d = 1'b1;
    end
    if (|(fired & SRC_CPU_MASK)) begin
      cpu_org_d = '{valid: 1'b1, source: first_src(fired & SRC_CPU_MASK)};
    end
    if (|(fired & SRC_BRD_MASK)) begin
      brd_org_d = '{valid: 1'b1, source: first_src(fired & SRC_BRD_MASK)};
    end
    // watchdog restarts on service or after it bites
    if (wdog_kick || wdog_expire) begin
      wdog_d = 17'h00000;
    end else begin
      wdog_d = wdog_q + 17'h00001;
    end
  end

  // register the reset-flag group
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      enable_q <= ENABLE_DEFAULT;
      flag_q <= 1'b0;
      cpu_rst_q <= 1'b0;
      brd_rst_q <= 1'b0;
      cpu_org_q <= '0;
      brd_org_q <= '0;
      wdog_q <= 17'h00000;
    end else begin
      enable_q <= enable_d;
      flag_q <= flag_d;
      cpu_rst_q <= cpu_rst_d;
      brd_rst_q <= brd_rst_d;
      cpu_org_q <= cpu_org_d;
      brd_org_q <= brd_org_d;
      wdog_q <= wdog_d;
    end
  end

  // ----------------------------------------------------------------
  // sync clock master / slave
  // ----------------------------------------------------------------
  // divider toggles the sync clock every half period in master role
  always_comb begin
    role_d = sync_master_sel ? SYNC_MASTER : SYNC_SLAVE;
    half_d = half_q;
    sync_d = sync_q;
    in_d = supply_sync_clock_in;
    seen_d = 1'b0;
    listen_d = (role_q == SYNC_SLAVE);
    case (role_q)
      SYNC_MASTER: begin
        if (half_q == 6'(SYNC_HALF_CYCLES - 1)) begin
          half_d = 6'h00;
          sync_d = ~sync_q;
        end else begin
          half_d = half_q + 6'h01;
        end
      end
      SYNC_SLAVE: begin
        // divider idles; watch for edges from the far crate
        half_d = 6'h00;
        sync_d = 1'b0;
        // first slave cycle compares against our own last drive: skip it,
        // otherwise a role change fakes an edge from the far crate
        seen_d = listen_q & (in_q ^ supply_sync_clock_in);
      end
      default: begin
        half_d = 6'h00;
        sync_d = 1'b0;
      end
    endcase
  end

  // register the sync group
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      role_q <= SYNC_SLAVE;
      half_q <= 6'h00;
      sync_q <= 1'b0;
      in_q <= 1'b0;
      seen_q <= 1'b0;
      listen_q <= 1'b0;
    end else begin
      role_q <= role_d;
      half_q <= half_d;
      sync_q <= sync_d;
      in_q <= in_d;
      seen_q <= seen_d;
      listen_q <= listen_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign cpu_reset = cpu_rst_q;
  assign board_reset = brd_rst_q;
  assign reset_flag = flag_q;
  assign reset_flag_led = flag_q;
  assign enable_state = enable_q;
  assign cpu_origin = cpu_org_q;
  assign board_origin = brd_org_q;
  assign supply_sync_clock_out = sync_q;
  // role register drives enable and led together
  assign supply_sync_clock_oe = role_q[1];
  assign master_led = role_q[1];
  assign sync_clock_seen = seen_q;

endmodule // reset_flag_sync

// *** bench/reset_flag_monitor.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module reset_flag_monitor
  import reset_flag_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // configuration
  input wire logic load_defaults,
  input wire logic cfg_write,
  input wire logic [5:0] cfg_enable,
  input wire logic sync_master_sel,
  // sources
  input wire logic cpu_failure_reset_source,
  input wire logic cpu_panel_reset_source,
  input wire logic board_panel_reset_source,
  // watched outputs
  input wire logic cpu_reset,
  input wire logic reset_flag,
  input wire logic reset_flag_led,
  input wire logic [5:0] enable_state,
  input wire reset_origin_t cpu_origin,
  input wire logic supply_sync_clock_out,
  input wire logic supply_sync_clock_oe,
  input wire logic master_led
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // gated events, seen through the registered enables
  wire f_ev = cpu_failure_reset_source & enable_state[SRC_CPU_FAIL];
  wire p_ev = cpu_panel_reset_source & enable_state[SRC_CPU_PANEL];
  wire b_ev = board_panel_reset_source & enable_state[SRC_BRD_PANEL];

  a_led_follows_flag: assert property (reset_flag_led == reset_flag)
    else $error("led differs from flag");
  a_cpu_event_acts: assert property (f_ev || p_ev |=> cpu_reset && reset_flag)
    else $error("enabled cpu event lost");
  a_cpu_event_ignored: assert property (!f_ev && !p_ev |=> !cpu_reset)
    else $error("cpu reset without enabled event");
  a_flag_sticky: assert property (
    reset_flag && !cfg_write && !load_defaults |=> reset_flag)
    else $error("flag dropped on its own");
  a_flag_cleared: assert property (
    cfg_write && !f_ev && !p_ev && !b_ev && !enable_state[SRC_BRD_WDOG] |=> !reset_flag)
    else $error("flag not cleared by reconfiguration");
  a_defaults_applied: assert property (
    load_defaults |=> enable_state == ENABLE_DEFAULT)
    else $error("defaults not applied");
  a_enable_written: assert property (cfg_write && !load_defaults
    |=> enable_state == $past(cfg_enable)) else $error("enables not written");
  a_cpu_origin: assert property (p_ev && !f_ev |=> cpu_origin == 4'hA)
    else $error("cpu origin wrong");
  a_master_drives: assert property (
    sync_master_sel |=> supply_sync_clock_oe && master_led)
    else $error("master role not taken");
  a_slave_listens: assert property (
    !sync_master_sel |=> !supply_sync_clock_oe && !master_led)
    else $error("slave role not taken");
  a_sync_half_period: assert property ($rose(supply_sync_clock_out) && sync_master_sel
    |-> ##50 ($fell(supply_sync_clock_out) || !master_led)) else $error("sync half period wrong");
endmodule // reset_flag_monitor

bind reset_flag_sync reset_flag_monitor mon (
  .mclk(mclk),
  .reset_n(reset_n),
  .load_defaults(load_defaults),
  .cfg_write(cfg_write),
  .cfg_enable(cfg_enable),
  .sync_master_sel(sync_master_sel),
  .cpu_failure_reset_source(cpu_failure_reset_source),
  .cpu_panel_reset_source(cpu_panel_reset_source),
  .board_panel_reset_source(board_panel_reset_source),
  .cpu_reset(cpu_reset),
  .reset_flag(reset_flag),
  .reset_flag_led(reset_flag_led),
  .enable_state(enable_state),
  .cpu_origin(cpu_origin),
  .supply_sync_clock_out(supply_sync_clock_out),
  .supply_sync_clock_oe(supply_sync_clock_oe),
  .master_led(master_led)
);

// *** bench/sync_partner.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far crate sync clock source
// ----------------------------------------------------------------
module sync_partner
  import reset_flag_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // high while the device listens
  input wire logic run,
  // external sync clock
  output logic clk_out
);
  int unsigned cnt; // half period counter
  // square wave at the sync rate, parked low while the device drives
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      clk_out <= 1'b0;
    end else if (cnt == SYNC_HALF_CYCLES - 1) begin
      cnt <= 0;
      clk_out <= run ? ~clk_out : 1'b0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // sync_partner

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import reset_flag_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic mclk = 0, reset_n = 0, load_defaults = 0, cfg_write = 0;
  logic sync_master_sel = 0, wdog_kick = 1;
  logic [5:0] cfg_enable = 6'h00, src = 6'h00;
  logic cpu_reset, board_reset, reset_flag, reset_flag_led, oe, out;
  logic master_led, seen, ext_clk, prev;
  logic [5:0] enable_state;
  reset_origin_t cpu_origin, board_origin;
  wire pin = oe ? out : ext_clk; // wire level from both drivers
  int num_errors = 0, total_checks = 0, n;

  initial forever #4 mclk = ~mclk;

  reset_flag_sync #(.WDOG_CYCLES(20)) dut (.*, .cpu_failure_reset_source(src[0]),
    .cpu_user_soft_reset_source(src[1]), .cpu_panel_reset_source(src[2]),
    .board_user_soft_reset_source(src[3]), .board_panel_reset_source(src[4]),
    .supply_sync_clock_in(pin), .supply_sync_clock_out(out), .supply_sync_clock_oe(oe),
    .sync_clock_seen(seen));
  sync_partner p (.mclk(mclk), .reset_n(reset_n), .run(!oe), .clk_out(ext_clk));

  // status bundle: cpu, board, flag, led, oe, master led
  function automatic logic [5:0] st();
    return {cpu_reset, board_reset, reset_flag, reset_flag_led, oe, master_led};
  endfunction
  task automatic chk(input string nm, input logic [5:0] sv, input logic [5:0] ev_v);
    total_checks++;
    if (sv !== ev_v) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, ev_v, sv);
    end
  endtask
  // one-cycle source event, returns once its answer has landed
  task automatic ev(input logic [5:0] s);
    @(posedge mclk) src <= s;
    @(posedge mclk) src <= 6'h00;
    #1;
  endtask
  task automatic cfg(input logic [5:0] e);
    @(posedge mclk) begin
      cfg_enable <= e;
      cfg_write <= 1'b1;
    end
    @(posedge mclk) cfg_write <= 1'b0;
    #1;
  endtask
  // bounded wait for the next change of the driven sync clock
  task automatic wait_chg();
    prev = out;
    for (n = 0; n < 200 && out === prev; n++) @(posedge mclk) #1;
    chk("sync toggle", {5'h00, out !== prev}, 6'h01);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk) #1;
    chk("enables", enable_state, ENABLE_DEFAULT);
    chk("status", st(), 6'h00);
    ev(6'h04);
    chk("status", st(), 6'h2C);
    chk("cpu origin", {2'h0, cpu_origin}, 6'h0A);
    @(posedge mclk) #1;
    chk("status", st(), 6'h0C);
    ev(6'h10);
    chk("status", st(), 6'h1C);
    chk("board origin", {2'h0, board_origin}, 6'h0C);
    cfg(6'h00);
    chk("status", st(), 6'h00);
    ev(6'h04);
    chk("status", st(), 6'h00);
    cfg(6'h3F);
    ev(6'h0A);
    chk("status", st(), 6'h00);
    ev(6'h05);
    chk("cpu origin", {2'h0, cpu_origin}, 6'h08);
    @(posedge mclk) wdog_kick <= 1'b0;
    for (n = 0; n < 30 && board_reset !== 1'b1; n++) @(posedge mclk) #1;
    chk("wdog reset", {5'h00, board_reset}, 6'h01);
    chk("board origin", {2'h0, board_origin}, 6'h0D);
    @(posedge mclk) wdog_kick <= 1'b1;
    @(posedge mclk) load_defaults <= 1'b1;
    @(posedge mclk) load_defaults <= 1'b0;
    #1;
    chk("enables", enable_state, ENABLE_DEFAULT);
    @(posedge mclk) sync_master_sel <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("status", st(), 6'h03);
    wait_chg();
    wait_chg();
    chk("half period", 6'(n), 6'h32);
    @(posedge mclk) sync_master_sel <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("status", st(), 6'h00);
    for (n = 0; n < 120 && seen !== 1'b1; n++) @(posedge mclk) #1;
    chk("sync seen", {5'h00, seen}, 6'h01);
    // next far-side edge must follow one half period later, not a fake one
    @(posedge mclk) #1;
    for (n = 1; n < 120 && seen !== 1'b1; n++) @(posedge mclk) #1;
    chk("edge spacing", 6'(n), 6'h32);
    stop_test();
  end
endmodule // tb_top
